// [dsad_top.sv]
// Data-space access unit: address decode, lane select, paging and traps.
`timescale 1ns/10ps
`default_nettype none
module dsad_top (
  input  wire logic                  clk_in,          // Core clock.
  input  wire logic                  rstn_in,         // Synchronous reset, active low.
  // Read address generator.
  input  wire logic                  rd_req_in,       // Read request, one cycle.
  input  wire logic [15:0]           rd_addr_in,      // Read effective address.
  input  wire logic                  rd_byte_in,      // High for a byte read.
  input  wire logic                  rd_near_in,      // Use 13-bit near field.
  output logic      [15:0]           rd_data_out,     // Read result.
  output logic                       rd_valid_out,    // Read result valid pulse.
  // Write address generator.
  input  wire logic                  wr_req_in,       // Write request, one cycle.
  input  wire logic [15:0]           wr_addr_in,      // Write effective address.
  input  wire logic                  wr_byte_in,      // High for a byte write.
  input  wire logic                  wr_near_in,      // Use 13-bit near field.
  input  wire logic [15:0]           wr_data_in,      // Write data, byte in low lane.
  // Memory side.
  output logic                       mem_rd_en_out,   // Memory read strobe.
  output logic      [23:0]           mem_rd_addr_out, // Extended word-aligned read address.
  input  wire logic [15:0]           mem_rd_data_in,  // Memory read word.
  output logic      [1:0]            mem_wr_lane_out, // Write strobes, bit 1 high lane.
  output logic      [23:0]           mem_wr_addr_out, // Extended word-aligned write address.
  output logic      [15:0]           mem_wr_data_out, // Write word.
  output logic                       rd_paged_out,    // Current read is extended.
  output logic                       wr_paged_out,    // Current write is extended.
  output logic                       trap_out,        // Address-error trap pulse.
  // Pointer and working register helpers.
  input  wire logic                  ptr_upd_in,      // Post-increment request.
  input  wire logic [15:0]           ptr_in,          // Pointer value.
  input  wire logic                  ptr_byte_in,     // Byte-sized operation.
  output logic      [15:0]           ptr_out,         // Incremented pointer.
  input  wire logic                  wop_req_in,      // Working register op request.
  input  wire dsad_pkg::dsad_wop_t   wop_in,          // Operation.
  input  wire logic [15:0]           wreg_in,         // Current working register.
  input  wire logic [15:0]           wsrc_in,         // Source value.
  output logic      [15:0]           wreg_out,        // Working register result.
  output logic                       wreg_valid_out,  // Result valid pulse.
  output logic      [9:0]            rpag_out,        // Read page register.
  output logic      [8:0]            wpag_out         // Write page register.
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [9:0]          rpag;
    logic [8:0]          wpag;
    logic                rd_pend;
    logic                rd_byte;
    logic                rd_odd;
    logic                rd_misal;
    dsad_pkg::dsad_src_t rd_src;
    logic [23:0]         rd_ext;
    logic                rd_paged;
    logic [15:0]         rd_data;
    logic                rd_valid;
    logic [1:0]          wr_lane;
    logic [23:0]         wr_ext;
    logic [15:0]         wr_data;
    logic                wr_paged;
    logic                trap;
    logic [15:0]         ptr;
    logic [15:0]         wreg;
    logic                wreg_valid;
  } dsad_state_t;

  dsad_state_t st_reg;
  dsad_state_t st_next;

  logic [15:0] rd_ea;
  logic [15:0] wr_ea;
  logic        rd_in_base;
  logic        wr_in_base;
  logic [15:0] sel_word;
  logic [15:0] wr_word;
  logic [1:0]  wr_lanes;

  // ==========================================================================
  // Effective addresses; the near field reaches only the lowest 8 Kbytes.
  assign rd_ea = rd_near_in ? {3'h0, rd_addr_in[dsad_pkg::NEAR_W-1:0]} : rd_addr_in;
  assign wr_ea = wr_near_in ? {3'h0, wr_addr_in[dsad_pkg::NEAR_W-1:0]} : wr_addr_in;

  // Implemented base region is SFR space plus RAM; other unpaged addresses read zero.
  assign rd_in_base = (rd_ea <= dsad_pkg::RAM_HI);
  assign wr_in_base = (wr_ea <= dsad_pkg::RAM_HI);

  // Byte writes put the byte on both lanes; only one lane is strobed.
  assign wr_word  = wr_byte_in ? {wr_data_in[7:0], wr_data_in[7:0]} : wr_data_in;
  assign wr_lanes = wr_byte_in ? (wr_ea[0] ? 2'b10 : 2'b01) : 2'b11;

  // Word chosen for a completing read.
  always_comb begin
    case (st_reg.rd_src)
      dsad_pkg::DSAD_SRC_MEM:  sel_word = mem_rd_data_in;
      dsad_pkg::DSAD_SRC_RPAG: sel_word = {6'h00, st_reg.rpag};
      dsad_pkg::DSAD_SRC_WPAG: sel_word = {7'h00, st_reg.wpag};
      default:                 sel_word = 16'h0000;
    endcase
  end

  // ==========================================================================
  // Next-state logic.
  always_comb begin
    st_next            = st_reg;
    st_next.rd_valid   = 1'b0;
    st_next.trap       = 1'b0;
    st_next.wr_lane    = 2'b00;
    st_next.wreg_valid = 1'b0;

    // Second read cycle: memory word arrives and the lane is picked.
    if (st_reg.rd_pend) begin
      st_next.rd_pend  = 1'b0;
      st_next.rd_valid = 1'b1;
      if (st_reg.rd_byte) begin
        st_next.rd_data = {8'h00, st_reg.rd_odd ? sel_word[15:8] : sel_word[7:0]};
      end else begin
        st_next.rd_data = sel_word;
      end
      // The read still completes; the trap pulses in the same cycle as the result.
      st_next.trap = st_reg.rd_misal;
    end

    // First read cycle: decode, page and issue to memory.
    if (rd_req_in) begin
      st_next.rd_pend  = 1'b1;
      st_next.rd_byte  = rd_byte_in;
      st_next.rd_odd   = rd_ea[0];
      st_next.rd_misal = !rd_byte_in && rd_ea[0];
      st_next.rd_paged = 1'b0;
      st_next.rd_ext   = {8'h00, rd_ea[15:1], 1'b0};
      if (rd_ea[15]) begin
        if (!st_reg.rpag[9]) begin
          st_next.rd_paged = 1'b1;
          st_next.rd_ext   = {st_reg.rpag[8:0], rd_ea[14:1], 1'b0};
          st_next.rd_src   = dsad_pkg::DSAD_SRC_MEM;
        end else begin
          st_next.rd_src   = dsad_pkg::DSAD_SRC_ZERO;
        end
      end else if (!rd_in_base) begin
        st_next.rd_src = dsad_pkg::DSAD_SRC_ZERO;
      end else if (rd_ea[15:1] == dsad_pkg::RPAG_ADDR[15:1]) begin
        st_next.rd_src = dsad_pkg::DSAD_SRC_RPAG;
      end else if (rd_ea[15:1] == dsad_pkg::WPAG_ADDR[15:1]) begin
        st_next.rd_src = dsad_pkg::DSAD_SRC_WPAG;
      end else begin
        st_next.rd_src = dsad_pkg::DSAD_SRC_MEM;
      end
    end

    // Write: decode and strobe in one cycle; a misaligned word is dropped.
    st_next.wr_paged = 1'b0;
    if (wr_req_in) begin
      st_next.wr_data = wr_word;
      st_next.wr_ext  = {8'h00, wr_ea[15:1], 1'b0};
      if (!wr_byte_in && wr_ea[0]) begin
        st_next.trap = 1'b1;
      end else if (wr_ea[15]) begin
        st_next.wr_paged = 1'b1;
        st_next.wr_ext   = {st_reg.wpag, wr_ea[14:1], 1'b0};
        st_next.wr_lane  = wr_lanes;
      end else if (!wr_in_base) begin
        st_next.wr_lane = 2'b00;
      end else if (wr_ea[15:1] == dsad_pkg::RPAG_ADDR[15:1]) begin
        // Page registers honour the byte lanes like any SFR.
        if (wr_lanes[0]) st_next.rpag[7:0] = wr_word[7:0];
        if (wr_lanes[1]) st_next.rpag[9:8] = wr_word[9:8];
      end else if (wr_ea[15:1] == dsad_pkg::WPAG_ADDR[15:1]) begin
        if (wr_lanes[0]) st_next.wpag[7:0] = wr_word[7:0];
        if (wr_lanes[1]) st_next.wpag[8]   = wr_word[8];
      end else begin
        st_next.wr_lane = wr_lanes;
      end
    end

    // Pointer post-increment.
    if (ptr_upd_in) begin
      st_next.ptr = ptr_in + (ptr_byte_in ? dsad_pkg::BYTE_STEP : dsad_pkg::WORD_STEP);
    end

    // Working register byte load and extensions.
    if (wop_req_in) begin
      st_next.wreg_valid = 1'b1;
      case (wop_in)
        dsad_pkg::DSAD_WOP_LOAD_BYTE: st_next.wreg = {wreg_in[15:8], wsrc_in[7:0]};
        dsad_pkg::DSAD_WOP_SIGN_EXT:  st_next.wreg = {{8{wsrc_in[7]}}, wsrc_in[7:0]};
        dsad_pkg::DSAD_WOP_ZERO_EXT:  st_next.wreg = {8'h00, wsrc_in[7:0]};
        default:                      st_next.wreg = wsrc_in;
      endcase
    end
  end

  // ==========================================================================
  // State register with synchronous reset.
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      st_reg      <= '0;
      st_reg.rpag <= dsad_pkg::RPAG_RST;
      st_reg.wpag <= dsad_pkg::WPAG_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // Outputs; the memory read strobe only fires for sources backed by memory.
  assign mem_rd_en_out   = st_reg.rd_pend && (st_reg.rd_src == dsad_pkg::DSAD_SRC_MEM);
  assign mem_rd_addr_out = st_reg.rd_ext;
  assign rd_paged_out    = st_reg.rd_pend && st_reg.rd_paged;
  assign rd_data_out     = st_reg.rd_data;
  assign rd_valid_out    = st_reg.rd_valid;
  assign mem_wr_lane_out = st_reg.wr_lane;
  assign mem_wr_addr_out = st_reg.wr_ext;
  assign mem_wr_data_out = st_reg.wr_data;
  assign wr_paged_out    = st_reg.wr_paged;
  assign trap_out        = st_reg.trap;
  assign ptr_out         = st_reg.ptr;
  assign wreg_out        = st_reg.wreg;
  assign wreg_valid_out  = st_reg.wreg_valid;
  assign rpag_out        = st_reg.rpag;
  assign wpag_out        = st_reg.wpag;

endmodule : dsad_top
`default_nettype wire

// [dsad_pkg.sv]
// Constants and types shared by the data-space address decode block.
// How it works
// - Separate read and write address generator ports.
// - Effective addresses are 16-bit byte addresses.
// - Unpaged reads outside SFR plus RAM read zero.
// - Little-endian words: even byte is low.
// - Pointer post-increment: byte adds one, word two.
// - Byte read picks lane, returns on low.
// - Byte write strobes only the addressed lane.
// - Odd word address raises address-error trap.
// - Misaligned read completes; misaligned write suppressed.
// - Byte load changes only working low byte.
// - Sign-extend and zero-extend working register ops.
// - Lowest 4 Kbytes decode to SFR space.
// - Unused SFR addresses read as zero; here they are read from memory like RAM.
// - Near space reached by 13-bit address.
// - Whole space reached by 16-bit address.
// - Read page 10 bits, write page 9.
// - Paged read: page bits over address bits.
// - Paged write: page bits over address bits.
package dsad_pkg;

  // ==========================================================================
  // Widths
  localparam int EA_W   = 16;
  localparam int EXT_W  = 24;
  localparam int RPAG_W = 10;
  localparam int WPAG_W = 9;
  localparam int NEAR_W = 13;

  // ==========================================================================
  // Address map of the base data space
  localparam logic [15:0] SFR_LO    = 16'h0000;
  localparam logic [15:0] SFR_HI    = 16'h0fff;
  localparam logic [15:0] RAM_LO    = 16'h1000;
  localparam logic [15:0] RAM_HI    = 16'h4fff;
  localparam logic [15:0] RPAG_ADDR = 16'h0032;
  localparam logic [15:0] WPAG_ADDR = 16'h0034;

  // ==========================================================================
  // Values after reset and pointer steps
  localparam logic [9:0]  RPAG_RST  = 10'h001;
  localparam logic [8:0]  WPAG_RST  = 9'h001;
  localparam logic [15:0] BYTE_STEP = 16'h0001;
  localparam logic [15:0] WORD_STEP = 16'h0002;

  // ==========================================================================
  // Working register operations
  typedef enum logic [1:0] {
    DSAD_WOP_LOAD_WORD,
    DSAD_WOP_LOAD_BYTE,
    DSAD_WOP_SIGN_EXT,
    DSAD_WOP_ZERO_EXT
  } dsad_wop_t;

  // Source of a read's data.
  typedef enum logic [1:0] {
    DSAD_SRC_MEM,
    DSAD_SRC_RPAG,
    DSAD_SRC_WPAG,
    DSAD_SRC_ZERO
  } dsad_src_t;

endpackage : dsad_pkg

// [dsad_sva.sv]
// Port checker for the data-space access unit.
`timescale 1ns/10ps
`default_nettype none
module dsad_sva (
  input wire logic        clk_in, rstn_in, rd_req_in, rd_byte_in, rd_near_in, rd_valid_out,
  input wire logic        wr_req_in, wr_byte_in, wr_near_in, mem_rd_en_out, rd_paged_out, trap_out,
  input wire logic        ptr_upd_in, ptr_byte_in,
  input wire logic [15:0] rd_addr_in, wr_addr_in, rd_data_out, ptr_in, ptr_out,
  input wire logic [23:0] mem_rd_addr_out, mem_wr_addr_out,
  input wire logic [1:0]  mem_wr_lane_out,
  input wire logic [9:0]  rpag_out,
  input wire logic [8:0]  wpag_out
);
  // ====================
  // Single clock domain, so one default clocking and reset serve all.
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  sequence s_rd_done; ##2 rd_valid_out; endsequence
  property p_rd_lat; rd_req_in |-> s_rd_done; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read result late");
  property p_rd_only; rd_valid_out |-> $past(rd_req_in, 2); endproperty
  a_rd_only: assert property (p_rd_only) else $error("read result without request");
  property p_rd_trap; rd_req_in && !rd_byte_in && rd_addr_in[0] |-> s_rd_done ##0 trap_out; endproperty
  a_rd_trap: assert property (p_rd_trap) else $error("odd word read gave no trap");
  property p_wr_trap; wr_req_in && !wr_byte_in && wr_addr_in[0] |=> trap_out && mem_wr_lane_out == 2'b00; endproperty
  a_wr_trap: assert property (p_wr_trap) else $error("odd word write not suppressed");
  property p_lane;
    wr_req_in && wr_byte_in && wr_addr_in[15] && !wr_near_in |=>
      mem_wr_lane_out == ($past(wr_addr_in[0]) ? 2'b10 : 2'b01);
  endproperty
  a_lane: assert property (p_lane) else $error("byte write lane wrong");
  property p_ptr; ptr_upd_in |=> ptr_out == $past(ptr_in) + ($past(ptr_byte_in) ? 16'h0001 : 16'h0002); endproperty
  a_ptr: assert property (p_ptr) else $error("pointer step wrong");
  property p_rpage;
    rd_req_in && rd_addr_in[15] && !rpag_out[9] && !rd_near_in |=> mem_rd_en_out && rd_paged_out &&
      mem_rd_addr_out == {$past(rpag_out[8:0]), $past(rd_addr_in[14:1]), 1'b0};
  endproperty
  a_rpage: assert property (p_rpage) else $error("paged read address wrong");
  property p_wpage;
    wr_req_in && wr_addr_in[15] && !wr_near_in && (wr_byte_in || !wr_addr_in[0]) |=>
      mem_wr_addr_out == {$past(wpag_out), $past(wr_addr_in[14:1]), 1'b0};
  endproperty
  a_wpage: assert property (p_wpage) else $error("paged write address wrong");
  property p_unpaged;
    rd_req_in && !rd_near_in && rd_addr_in inside {[16'h1000:16'h4fff]} |=> mem_rd_en_out && !rd_paged_out &&
      mem_rd_addr_out == {8'h00, $past(rd_addr_in[15:1]), 1'b0};
  endproperty
  a_unpaged: assert property (p_unpaged) else $error("base read address wrong");
  property p_zero;
    rd_req_in && !rd_near_in && !rd_addr_in[15] && rd_addr_in > 16'h4fff |=> !mem_rd_en_out ##1 rd_data_out == 16'h0000;
  endproperty
  a_zero: assert property (p_zero) else $error("unimplemented read not zero");
endmodule : dsad_sva
bind dsad_top dsad_sva u_sva (.*);
`default_nettype wire

// [dsad_mem_model.sv]
// Behavioural word memory at the far side of the access unit.
`timescale 1ns/10ps
`default_nettype none
module dsad_mem_model (
  input  wire logic        clk_in,      // Core clock.
  input  wire logic        rd_en_in,    // Read strobe.
  input  wire logic [23:0] rd_addr_in,  // Word read address.
  output logic      [15:0] rd_data_out, // Read word.
  input  wire logic [1:0]  wr_lane_in,  // Lane strobes.
  input  wire logic [23:0] wr_addr_in,  // Word write address.
  input  wire logic [15:0] wr_data_in   // Write word.
);
  // ====================
  // Sparse store; words never written read as zero like unused space.
  logic [15:0] mem [int];
  logic [15:0] last_q = 16'h0000;
  // Only strobed lanes change, so a byte write keeps its partner byte.
  always @(posedge clk_in) begin : wr_p
    logic [15:0] w;
    w = mem.exists(wr_addr_in) ? mem[wr_addr_in] : 16'h0000;
    if (wr_lane_in[0]) w[7:0] = wr_data_in[7:0];
    if (wr_lane_in[1]) w[15:8] = wr_data_in[15:8];
    if (wr_lane_in != 2'b00) mem[wr_addr_in] = w;
    if (rd_en_in) last_q <= rd_data_out;
  end
  // Outside a strobe the bus shows the inverse word, never a stale copy.
  always @* begin
    if (rd_en_in) rd_data_out = mem.exists(rd_addr_in) ? mem[rd_addr_in] : 16'h0000;
    else rd_data_out = ~last_q;
  end
endmodule : dsad_mem_model
`default_nettype wire

// [testbench.sv]
// Self-checking testbench of the data-space access unit.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  // ====================
  logic clk_in = 1'b0, rstn_in = 1'b0, rd_req_in, rd_byte_in, rd_near_in, wr_req_in, wr_byte_in, wr_near_in;
  logic ptr_upd_in, ptr_byte_in, wop_req_in, rd_valid_out, mem_rd_en_out, rd_paged_out, wr_paged_out;
  logic trap_out, wreg_valid_out;
  logic [15:0] rd_addr_in, wr_addr_in, wr_data_in, ptr_in, wreg_in, wsrc_in, rd_data_out, mem_rd_data_in;
  logic [15:0] mem_wr_data_out, ptr_out, wreg_out;
  logic [23:0] mem_rd_addr_out, mem_wr_addr_out;
  logic [1:0] mem_wr_lane_out;
  logic [9:0] rpag_out;
  logic [8:0] wpag_out;
  dsad_pkg::dsad_wop_t wop_in;
  logic [15:0] wexp [4] = '{16'h1a2b, 16'h3c2b, 16'hff85, 16'h0085};
  int errors = 0, compares = 0;
  dsad_top dut (.*);
  dsad_mem_model u_mem (.clk_in(clk_in), .rd_en_in(mem_rd_en_out), .rd_addr_in(mem_rd_addr_out),
    .rd_data_out(mem_rd_data_in), .wr_lane_in(mem_wr_lane_out), .wr_addr_in(mem_wr_addr_out),
    .wr_data_in(mem_wr_data_out));
  // Free-running 100 MHz core clock.
  always #5 clk_in = ~clk_in;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Read: request for one cycle, result lands one edge after it is taken.
  task automatic rd(input logic [15:0] a, input logic b, n, input logic [15:0] e, input logic t);
    @(posedge clk_in);
    {rd_req_in, rd_byte_in, rd_near_in, rd_addr_in} <= {1'b1, b, n, a};
    @(posedge clk_in);
    rd_req_in <= 1'b0;
    // The result pulse stands for one cycle only, right after the second edge.
    @(posedge clk_in);
    #1;
    chk("rd_valid", rd_valid_out, 1'b1);
    chk("rd_data", rd_data_out, e);
    chk("rd_trap", trap_out, t);
  endtask : rd
  // Write: strobes or trap appear right after the edge that takes the request.
  task automatic wr(input logic [15:0] a, input logic b, input logic [15:0] d, input logic t);
    @(posedge clk_in);
    {wr_req_in, wr_byte_in, wr_addr_in, wr_data_in} <= {1'b1, b, a, d};
    @(posedge clk_in);
    wr_req_in <= 1'b0;
    // Lanes, trap and page flag are one-cycle pulses after the taking edge.
    #1;
    chk("wr_trap", trap_out, t);
    chk("wr_paged", wr_paged_out, a[15] && !t);
    if (t) chk("wr_lanes", mem_wr_lane_out, 2'b00);
  endtask : wr
  task automatic report_and_stop;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  // Watchdog sized well above the roughly 80 cycles the tests need.
  initial begin
    repeat (3000) @(posedge clk_in);
    errors++;
    report_and_stop();
  end
  // Main sequence.
  initial begin
    {rd_req_in, rd_byte_in, rd_near_in, wr_req_in, wr_byte_in, wr_near_in, ptr_upd_in, ptr_byte_in} = '0;
    {wop_req_in, rd_addr_in, wr_addr_in, wr_data_in, ptr_in, wreg_in, wsrc_in} = '0;
    wop_in = dsad_pkg::DSAD_WOP_LOAD_WORD;
    repeat (16) @(posedge clk_in);
    rstn_in <= 1'b1;
    #1;
    chk("rpag_rst", rpag_out, 10'h001);
    chk("wpag_rst", wpag_out, 9'h001);
    $display("test reset done");
    wr(16'h1000, 1'b0, 16'ha5c3, 1'b0);
    wr(16'h1001, 1'b1, 16'h007e, 1'b0);
    rd(16'h1000, 1'b0, 1'b0, 16'h7ec3, 1'b0);
    rd(16'h1001, 1'b1, 1'b0, 16'h007e, 1'b0);
    rd(16'h1000, 1'b1, 1'b0, 16'h00c3, 1'b0);
    rd(16'hf000, 1'b0, 1'b1, 16'h7ec3, 1'b0);
    $display("test lanes done");
    wr(16'h1003, 1'b0, 16'hffff, 1'b1);
    rd(16'h1002, 1'b0, 1'b0, 16'h0000, 1'b0);
    rd(16'h1001, 1'b0, 1'b0, 16'h7ec3, 1'b1);
    wr(16'h6000, 1'b0, 16'h1111, 1'b0);
    rd(16'h6000, 1'b0, 1'b0, 16'h0000, 1'b0);
    $display("test alignment done");
    wr(16'h0034, 1'b0, 16'h0003, 1'b0);
    wr(16'h0032, 1'b0, 16'h0003, 1'b0);
    chk("wpag", wpag_out, 9'h003);
    wr(16'h8010, 1'b0, 16'h1234, 1'b0);
    chk("wr_ext", mem_wr_addr_out, 24'h018010);
    wr(16'h8011, 1'b1, 16'h0099, 1'b0);
    rd(16'h8010, 1'b0, 1'b0, 16'h9934, 1'b0);
    rd(16'h0032, 1'b0, 1'b0, 16'h0003, 1'b0);
    rd(16'h0010, 1'b0, 1'b0, 16'h0000, 1'b0);
    wr(16'h0032, 1'b0, 16'h0203, 1'b0);
    rd(16'h8010, 1'b0, 1'b0, 16'h0000, 1'b0);
    wr(16'h0034, 1'b0, 16'hffff, 1'b0);
    rd(16'h0034, 1'b0, 1'b0, 16'h01ff, 1'b0);
    $display("test paging done");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_in);
      {ptr_upd_in, ptr_in, ptr_byte_in, wop_req_in, wreg_in} <= {1'b1, 16'hfffe, i[0], 1'b1, 16'h3c85};
      wop_in <= dsad_pkg::dsad_wop_t'(i[1:0]);
      wsrc_in <= (i < 2) ? 16'h1a2b : 16'h3c85;
      @(posedge clk_in);
      {ptr_upd_in, wop_req_in} <= 2'b00;
      #1;
      chk("ptr", ptr_out, i[0] ? 16'hffff : 16'h0000);
      chk("wreg", wreg_out, wexp[i]);
      chk("wreg_valid", wreg_valid_out, 1'b1);
    end
    $display("test helpers done");
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
